// ===== core/ddrpin_lane_cap.sv
`timescale 1ns/100ps
// ****************************************************************
// One byte lane of read capture, timed by the returned strobe.
// ****************************************************************
module ddrpin_lane_cap
  import ddrpin_pkg::*;
(
  input  wire logic              core_clk_i,  // Core clock.
  input  wire logic              sys_rst_i,   // Asynchronous reset, active high.
  input  wire logic              win_i,       // Capture window open.
  input  wire logic [LANE_W-1:0] dq_i,        // Raw data pins of this lane.
  input  wire logic              strobe_p_i,  // Raw strobe, true part.
  input  wire logic              strobe_n_i,  // Raw strobe, complement part.
  output logic      [LANE_W-1:0] byte_o,      // Captured byte.
  output logic                   valid_o      // One-cycle pulse per captured byte.
);

  logic [LANE_W-1:0] dq_meta_reg;   // First synchroniser stage of data.
  logic [LANE_W-1:0] dq_sync_reg;   // Second synchroniser stage of data.
  logic [1:0]        stb_meta_reg;  // First stage of both strobe halves.
  logic [1:0]        stb_sync_reg;  // Second stage of both strobe halves.
  logic              stb_lvl_reg;   // Strobe level seen one cycle ago.
  logic [1:0]        edge_dly_reg;  // Edge pulse delayed toward mid beat.
  logic              stb_lvl;       // Decoded differential level.

  // ****************************************************************
  // Synchronisers; only the second stage is read by logic.
  // ****************************************************************
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dq_meta_reg  <= '0;
      dq_sync_reg  <= '0;
      stb_meta_reg <= 2'h0;
      stb_sync_reg <= 2'h0;
    end else begin
      dq_meta_reg  <= dq_i;
      dq_sync_reg  <= dq_meta_reg;
      stb_meta_reg <= {strobe_p_i, strobe_n_i};
      stb_sync_reg <= stb_meta_reg;
    end
  end

  // The pair counts as high only when the halves disagree the right way.
  assign stb_lvl = stb_sync_reg[1] & ~stb_sync_reg[0];

  // ****************************************************************
  // Edge detection; data is edge aligned, so sampling waits two cycles
  // to land in the middle of the beat rather than on its transition.
  // ****************************************************************
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stb_lvl_reg  <= 1'b0;
      edge_dly_reg <= 2'h0;
      byte_o       <= '0;
      valid_o      <= 1'b0;
    end else begin
      stb_lvl_reg  <= stb_lvl;
      edge_dly_reg <= {edge_dly_reg[0], win_i & (stb_lvl ^ stb_lvl_reg)};
      valid_o      <= edge_dly_reg[1];
      if (edge_dly_reg[1]) begin
        byte_o <= dq_sync_reg;
      end
    end
  end

endmodule : ddrpin_lane_cap

// ===== core/ddrpin_top.sv
`timescale 1ns/100ps
// What this block does
// - Drive 16-bit row and column address.
// - Drive 3-bit bank address with commands.
// - Forward true and complement memory clock.
// - Clock enable low stops, high runs memory.
// - Two active-low chip selects pick rank.
// - Low mask bits 7:0, high mask 15:8.
// - Strobes driven on writes, received on reads.
// - Capture read data with returned strobes.
// - Low strobe bits 7:0, high 15:8.
// - Commands encoded on strobes and chip selects.
// - Drive two on-die termination controls.
module ddrpin_top
  import ddrpin_pkg::*;
(
  input  wire logic                 core_clk_i,           // Core clock, 100 MHz.
  input  wire logic                 sys_rst_i,            // Asynchronous reset, active high.
  input  wire logic                 cmd_valid_i,          // Command request.
  input  wire ddrpin_cmd_e          cmd_code_i,           // Command code.
  input  wire logic                 cmd_rank_i,           // Target rank.
  input  wire logic [BANK_W-1:0]    cmd_bank_i,           // Target bank.
  input  wire logic [ADDR_W-1:0]    cmd_addr_i,           // Row or column address.
  input  wire logic [BEATS*DQ_W-1:0] cmd_wdata_i,         // Write data, beat 0 low.
  input  wire logic [BEATS*LANES-1:0] cmd_wmask_i,        // Write masks, high blocks.
  input  wire logic                 clk_en_req_i,         // Requested clock enable level.
  input  wire logic [1:0]           term_req_i,           // Requested termination levels.
  output logic                      cmd_ready_o,          // Sequencer idle.
  output logic                      cmd_ack_o,            // Command taken pulse.
  output logic [DQ_W-1:0]           rd_data_o,            // Read beat.
  output logic                      rd_valid_o,           // Read beat pulse.
  output logic [ADDR_W-1:0]         mem_addr_o,           // Address pins.
  output logic [BANK_W-1:0]         mem_bank_o,           // Bank pins.
  output logic                      mem_clk_true_o,       // Memory clock, true part.
  output logic                      mem_clk_comp_o,       // Memory clock, complement.
  output logic                      mem_clk_en_o,         // Memory clock enable.
  output logic [RANKS-1:0]          mem_rank_sel_n_o,     // Chip selects, active low.
  output logic                      mem_row_strobe_n_o,   // Row strobe, active low.
  output logic                      mem_col_strobe_n_o,   // Column strobe, active low.
  output logic                      mem_write_en_n_o,     // Write enable, active low.
  output logic [1:0]                mem_term_ctrl_o,      // On-die termination.
  output logic                      mem_mask_low_o,       // Mask for bits 7:0.
  output logic                      mem_mask_high_o,      // Mask for bits 15:8.
  input  wire logic [DQ_W-1:0]      mem_dq_i,             // Data pins in.
  output logic [DQ_W-1:0]           mem_dq_o,             // Data pins out.
  output logic [LANES-1:0]          mem_dq_oe_n_o,        // Data drive, low drives.
  input  wire logic                 mem_strobe_low_p_i,   // Low strobe true in.
  input  wire logic                 mem_strobe_low_n_i,   // Low strobe complement in.
  input  wire logic                 mem_strobe_high_p_i,  // High strobe true in.
  input  wire logic                 mem_strobe_high_n_i,  // High strobe complement in.
  output logic                      mem_strobe_low_p_o,   // Low strobe true out.
  output logic                      mem_strobe_low_n_o,   // Low strobe complement out.
  output logic                      mem_strobe_high_p_o,  // High strobe true out.
  output logic                      mem_strobe_high_n_o,  // High strobe complement out.
  output logic                      mem_strobe_oe_n_o     // Strobe drive, low drives.
);

  // ****************************************************************
  // Internal state.
  // ****************************************************************
  logic [1:0]            div_reg;      // Half period divider.
  ddrpin_state_e         state_reg;    // Sequencer state.
  logic [2:0]            phase_reg;    // Half periods left in a state.
  logic                  beat_reg;     // Write beat being driven.
  logic [BEATS*DQ_W-1:0] wdata_reg;    // Held write burst.
  logic [BEATS*LANES-1:0] wmask_reg;   // Held write masks.
  logic                  stb_reg;      // Write strobe level.
  logic                  tick;         // Half period enable pulse.
  logic                  fall_tick;    // Tick where the true clock falls.
  logic                  accept;       // Command taken this cycle.
  logic [DQ_W-1:0]       lane_data;    // Bytes from both lanes.
  logic [LANES-1:0]      lane_valid;   // Byte pulses from both lanes.

  assign tick      = (div_reg == DIV_LAST);
  assign fall_tick = tick & mem_clk_true_o;
  // Commands are launched on the falling edge so they sit still
  // across the next rising edge that the memory samples on.
  assign accept    = fall_tick & cmd_valid_i & cmd_ready_o;

  // ****************************************************************
  // Clock divider and forwarded differential clock.
  // ****************************************************************
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_reg        <= 2'h0;
      mem_clk_true_o <= 1'b0;
      mem_clk_comp_o <= 1'b1;
    end else begin
      div_reg <= div_reg + 2'h1;
      if (tick) begin
        mem_clk_true_o <= ~mem_clk_true_o;
        mem_clk_comp_o <= mem_clk_true_o;
      end
    end
  end

  // ****************************************************************
  // Clock enable and termination follow their requests per half period.
  // ****************************************************************
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mem_clk_en_o    <= 1'b0;
      mem_term_ctrl_o <= TERM_RST;
    end else if (tick) begin
      mem_clk_en_o    <= clk_en_req_i;
      mem_term_ctrl_o <= term_req_i;
    end
  end

  // ****************************************************************
  // Command pins: one full memory clock per command, deselect otherwise.
  // ****************************************************************
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mem_rank_sel_n_o   <= RANK_IDLE;
      mem_row_strobe_n_o <= 1'b1;
      mem_col_strobe_n_o <= 1'b1;
      mem_write_en_n_o   <= 1'b1;
      mem_addr_o         <= '0;
      mem_bank_o         <= '0;
      cmd_ack_o          <= 1'b0;
    end else begin
      cmd_ack_o <= accept;
      if (accept) begin
        // The enum value is the pin pattern of the standard table.
        {mem_row_strobe_n_o, mem_col_strobe_n_o, mem_write_en_n_o} <= cmd_code_i;
        mem_rank_sel_n_o <= cmd_rank_i ? 2'h1 : 2'h2;
        mem_addr_o       <= cmd_addr_i;
        mem_bank_o       <= cmd_bank_i;
      end else if (fall_tick) begin
        mem_rank_sel_n_o   <= RANK_IDLE;
        {mem_row_strobe_n_o, mem_col_strobe_n_o, mem_write_en_n_o} <= CMD_NOP;
      end
    end
  end

  // ****************************************************************
  // Sequencer for write bursts and read windows.
  // ****************************************************************
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg   <= ST_IDLE;
      phase_reg   <= 3'h0;
      beat_reg    <= 1'b0;
      wdata_reg   <= '0;
      wmask_reg   <= '0;
      cmd_ready_o <= 1'b1;
    end else begin
      if (accept) begin
        wdata_reg <= cmd_wdata_i;
        wmask_reg <= cmd_wmask_i;
      end
      if (tick) begin
        case (state_reg)
          ST_IDLE: begin
            if (accept && cmd_code_i == CMD_WR) begin
              state_reg <= ST_WR_LAT;
              phase_reg <= WR_LAT_TICKS;
            end else if (accept && cmd_code_i == CMD_RD) begin
              state_reg <= ST_RD_WIN;
              phase_reg <= RD_WIN_TICKS;
            end
          end
          ST_WR_LAT: begin
            if (phase_reg == 3'h0) begin
              state_reg <= ST_WR_PRE;
            end else begin
              phase_reg <= phase_reg - 3'h1;
            end
          end
          ST_WR_PRE: begin
            state_reg <= ST_WR_DAT;
            beat_reg  <= 1'b0;
          end
          ST_WR_DAT: begin
            // Two beats, one per half period, then back to idle.
            if (beat_reg) begin
              state_reg <= ST_IDLE;
            end
            beat_reg <= ~beat_reg;
          end
          ST_RD_WIN: begin
            if (phase_reg == 3'h0) begin
              state_reg <= ST_IDLE;
            end else begin
              phase_reg <= phase_reg - 3'h1;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
      // Ready drops with the command that is taken, rises on return to idle.
      cmd_ready_o <= accept ? 1'b0 : (state_reg == ST_IDLE);
    end
  end

  // ****************************************************************
  // Write data path: data, masks and strobes driven only on writes.
  // The strobe toggles at mid half period so it sits centred on data.
  // ****************************************************************
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mem_dq_o          <= '0;
      mem_dq_oe_n_o     <= 2'h3;
      mem_mask_low_o    <= 1'b1;
      mem_mask_high_o   <= 1'b1;
      stb_reg           <= 1'b0;
      mem_strobe_oe_n_o <= 1'b1;
    end else begin
      mem_strobe_oe_n_o <= ~(state_reg == ST_WR_PRE || state_reg == ST_WR_DAT);
      if (state_reg == ST_WR_DAT) begin
        mem_dq_o        <= wdata_reg[beat_reg*DQ_W +: DQ_W];
        mem_dq_oe_n_o   <= 2'h0;
        mem_mask_low_o  <= wmask_reg[beat_reg*LANES];
        mem_mask_high_o <= wmask_reg[beat_reg*LANES + 1];
        if (div_reg == DIV_MID) begin
          stb_reg <= ~stb_reg;
        end
      end else begin
        // Not writing: release data and mask every lane.
        mem_dq_oe_n_o   <= 2'h3;
        mem_mask_low_o  <= 1'b1;
        mem_mask_high_o <= 1'b1;
        stb_reg         <= 1'b0;
      end
    end
  end

  // Both strobe pairs carry the same differential write strobe.
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mem_strobe_low_p_o  <= 1'b0;
      mem_strobe_low_n_o  <= 1'b1;
      mem_strobe_high_p_o <= 1'b0;
      mem_strobe_high_n_o <= 1'b1;
    end else begin
      mem_strobe_low_p_o  <= stb_reg;
      mem_strobe_low_n_o  <= ~stb_reg;
      mem_strobe_high_p_o <= stb_reg;
      mem_strobe_high_n_o <= ~stb_reg;
    end
  end

  // ****************************************************************
  // Read capture, one instance per byte lane with its own strobe.
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      ddrpin_lane_cap u_cap (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .win_i      (state_reg == ST_RD_WIN),
        .dq_i       (mem_dq_i[g*LANE_W +: LANE_W]),
        .strobe_p_i (g == 0 ? mem_strobe_low_p_i : mem_strobe_high_p_i),
        .strobe_n_i (g == 0 ? mem_strobe_low_n_i : mem_strobe_high_n_i),
        .byte_o     (lane_data[g*LANE_W +: LANE_W]),
        .valid_o    (lane_valid[g])
      );
    end
  endgenerate

  // A beat is complete when both lanes have caught their byte.
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_data_o  <= '0;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= &lane_valid;
      if (&lane_valid) begin
        rd_data_o <= lane_data;
      end
    end
  end

  // ****************************************************************
  // Assertions and covers.
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_clk_pair_opposite: assert property (mem_clk_comp_o == ~mem_clk_true_o)
    else $error("memory clock halves not complementary");
  a_addr_follows: assert property (accept |=> mem_addr_o == $past(cmd_addr_i))
    else $error("address pins did not take command address");
  a_bank_follows: assert property (accept |=> mem_bank_o == $past(cmd_bank_i))
    else $error("bank pins did not take command bank");
  a_rank_select_low: assert property (accept |=> mem_rank_sel_n_o[$past(cmd_rank_i)] == 1'b0
      && mem_rank_sel_n_o[~$past(cmd_rank_i)] == 1'b1)
    else $error("wrong rank selected");
  a_read_cmd_code: assert property (accept && cmd_code_i == CMD_RD |=>
      {mem_row_strobe_n_o, mem_col_strobe_n_o, mem_write_en_n_o} == 3'h5)
    else $error("read command pattern wrong");
  // The pins change on the cycle after the accept, then stand until the next fall tick.
  a_cmd_held_period: assert property (accept |=> ##1 $stable({mem_row_strobe_n_o,
      mem_col_strobe_n_o, mem_write_en_n_o, mem_rank_sel_n_o})[*7])
    else $error("command pins did not stand a full clock");
  a_clk_en_follow: assert property ($rose(clk_en_req_i) ##1 clk_en_req_i[*5] |-> mem_clk_en_o)
    else $error("clock enable did not follow request");
  a_term_follow: assert property ($changed(term_req_i) ##1 $stable(term_req_i)[*5]
      |-> mem_term_ctrl_o == term_req_i)
    else $error("termination did not follow request");
  a_strobe_with_data: assert property (mem_dq_oe_n_o == 2'h0 |-> !mem_strobe_oe_n_o
      && mem_strobe_low_p_o != mem_strobe_low_n_o)
    else $error("data driven without differential strobe");
  a_mask_when_idle: assert property (mem_dq_oe_n_o == 2'h3 |-> mem_mask_low_o && mem_mask_high_o)
    else $error("mask low while not writing");
  a_no_drive_read: assert property (state_reg == ST_RD_WIN |=> mem_strobe_oe_n_o
      && mem_dq_oe_n_o == 2'h3)
    else $error("pins driven during read window");

  c_write_taken: cover property (accept && cmd_code_i == CMD_WR);
  c_read_taken: cover property (accept && cmd_code_i == CMD_RD);
  c_read_beat: cover property (rd_valid_o);
  c_write_beat: cover property (mem_dq_oe_n_o == 2'h0 ##1 mem_dq_oe_n_o == 2'h3);

endmodule : ddrpin_top

// ===== include/ddrpin_pkg.sv
// ****************************************************************
// Shared constants for the memory pin interface.
// ****************************************************************
package ddrpin_pkg;

  // ****************************************************************
  // Widths of the pin groups.
  // ****************************************************************
  localparam int ADDR_W  = 16;  // Row and column address width.
  localparam int BANK_W  = 3;   // Bank address width.
  localparam int RANKS   = 2;   // Chip selects, one per rank.
  localparam int DQ_W    = 16;  // Data bus width.
  localparam int LANE_W  = 8;   // Bits qualified by one strobe and one mask.
  localparam int LANES   = 2;   // Byte lanes on the data bus.
  localparam int BEATS   = 2;   // Data beats carried by one burst.

  // ****************************************************************
  // Timing counts, in core clock cycles or memory clock half periods.
  // ****************************************************************
  localparam logic [1:0] DIV_LAST     = 2'h3;  // Core cycles per half period, minus one.
  localparam logic [1:0] DIV_MID      = 2'h1;  // Strobe edge point inside a half period.
  localparam logic [2:0] WR_LAT_TICKS = 3'h4;  // Half periods from write command to preamble, minus one.
  localparam logic [2:0] RD_WIN_TICKS = 3'h7;  // Half periods the read capture stays open, minus one.

  // ****************************************************************
  // Reset values of the pins.
  // ****************************************************************
  localparam logic [RANKS-1:0] RANK_IDLE = 2'h3;  // Both ranks deselected.
  localparam logic [1:0]       TERM_RST  = 2'h0;  // Termination off.

  // Command codes; the value is the row, column and write strobe pattern.
  typedef enum logic [2:0] {
    CMD_MRS = 3'h0,  // Mode register set.
    CMD_REF = 3'h1,  // Refresh.
    CMD_PRE = 3'h2,  // Precharge.
    CMD_ACT = 3'h3,  // Activate a row.
    CMD_WR  = 3'h4,  // Write burst.
    CMD_RD  = 3'h5,  // Read burst.
    CMD_ZQC = 3'h6,  // Impedance calibration.
    CMD_NOP = 3'h7   // No operation.
  } ddrpin_cmd_e;

  // Sequencer states, Gray coded along the write path.
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,  // Waiting for a command.
    ST_WR_LAT = 3'h1,  // Waiting out write latency.
    ST_WR_PRE = 3'h3,  // Strobe preamble.
    ST_WR_DAT = 3'h2,  // Write data beats.
    ST_RD_WIN = 3'h6   // Read capture window.
  } ddrpin_state_e;

endpackage : ddrpin_pkg

// ===== tb/ddrpin_mem_model.sv
`timescale 1ns/100ps
// Behavioural memory: takes write bytes on the device's strobes and answers one read burst.
module ddrpin_mem_model
  import ddrpin_pkg::*;
(
  input  wire logic [1:0]  mem_rank_sel_n_o,    // Chip selects.
  input  wire logic        mem_row_strobe_n_o,  // Row strobe.
  input  wire logic        mem_col_strobe_n_o,  // Column strobe.
  input  wire logic        mem_write_en_n_o,    // Write enable.
  input  wire logic        mem_mask_low_o,      // Low mask.
  input  wire logic        mem_mask_high_o,     // High mask.
  input  wire logic [15:0] mem_dq_o,            // Data out.
  input  wire logic [1:0]  mem_dq_oe_n_o,       // Data drive, low.
  input  wire logic        mem_strobe_low_p_o,  // Low strobe out.
  input  wire logic        mem_strobe_high_p_o, // High strobe out.
  input  wire logic        mem_strobe_oe_n_o,   // Strobe drive, low.
  input  wire logic [31:0] rdat,                // Burst to return.
  output logic      [15:0] mem_dq_i,            // Resolved data.
  output logic             mem_strobe_low_p_i,  // Low strobe.
  output logic             mem_strobe_low_n_i,  // Its complement.
  output logic             mem_strobe_high_p_i, // High strobe.
  output logic             mem_strobe_high_n_i, // Its complement.
  output logic      [31:0] wdat                 // Bytes written.
);
  logic [15:0] md = 16'h0;  // Data the memory drives.
  logic        ms = 1'b0;   // Strobe the memory drives.
  wire         sel = &mem_rank_sel_n_o;  // Falls when a rank is selected.
  // Each pin shows whichever side drives it.
  assign mem_dq_i[7:0] = mem_dq_oe_n_o[0] ? md[7:0] : mem_dq_o[7:0];
  assign mem_dq_i[15:8] = mem_dq_oe_n_o[1] ? md[15:8] : mem_dq_o[15:8];
  assign mem_strobe_low_p_i = mem_strobe_oe_n_o ? ms : mem_strobe_low_p_o;
  assign mem_strobe_low_n_i = ~mem_strobe_low_p_i;
  assign mem_strobe_high_p_i = mem_strobe_oe_n_o ? ms : mem_strobe_high_p_o;
  assign mem_strobe_high_n_i = ~mem_strobe_high_p_i;
  // Read: data moves with each strobe edge; slow 80 ns beats; released lines invert.
  always @(negedge sel) if ({mem_row_strobe_n_o, mem_col_strobe_n_o, mem_write_en_n_o} == 3'h5) begin
    #101 ms = 1'b1;
    md = rdat[15:0];
    #80 ms = 1'b0;
    md = rdat[31:16];
    #220 ms = 1'b1;
    md = ~md;
  end
  // Write: each lane on its own strobe, rise is beat 0, fall beat 1; masked bytes kept.
  initial wdat = 32'h0;
  always @(mem_strobe_low_p_o) if (!mem_strobe_oe_n_o && !mem_mask_low_o) begin
    if (mem_strobe_low_p_o) wdat[7:0] = mem_dq_o[7:0];
    else wdat[23:16] = mem_dq_o[7:0];
  end
  always @(mem_strobe_high_p_o) if (!mem_strobe_oe_n_o && !mem_mask_high_o) begin
    if (mem_strobe_high_p_o) wdat[15:8] = mem_dq_o[15:8];
    else wdat[31:24] = mem_dq_o[15:8];
  end
endmodule : ddrpin_mem_model

// ===== tb/tb_top.sv
`timescale 1ns/100ps
// Bench: each task drives one scenario and judges it before returning.
module tb_top
  import ddrpin_pkg::*;
;
  logic core_clk_i, sys_rst_i, cmd_valid_i, cmd_rank_i, clk_en_req_i, cmd_ready_o, cmd_ack_o;
  logic rd_valid_o, mem_clk_true_o, mem_clk_comp_o, mem_clk_en_o, mem_row_strobe_n_o;
  logic mem_col_strobe_n_o, mem_write_en_n_o, mem_mask_low_o, mem_mask_high_o;
  logic mem_strobe_oe_n_o, mem_strobe_low_p_o, mem_strobe_low_n_o, mem_strobe_high_p_o;
  logic mem_strobe_high_n_o, mem_strobe_low_p_i, mem_strobe_low_n_i, mem_strobe_high_p_i;
  logic mem_strobe_high_n_i;
  logic [1:0] term_req_i, mem_rank_sel_n_o, mem_term_ctrl_o, mem_dq_oe_n_o;
  logic [2:0] cmd_bank_i, mem_bank_o;
  logic [3:0] cmd_wmask_i;
  logic [15:0] cmd_addr_i, rd_data_o, mem_addr_o, mem_dq_o, mem_dq_i;
  logic [31:0] cmd_wdata_i, wdat;
  logic [31:0] rdat = 32'h5A3C96E1;  // Burst the memory returns.
  ddrpin_cmd_e cmd_code_i;
  int failures, n_compared, cycles;
  ddrpin_top u_dut (.core_clk_i, .sys_rst_i, .cmd_valid_i, .cmd_code_i, .cmd_rank_i, .cmd_bank_i,
    .cmd_addr_i, .cmd_wdata_i, .cmd_wmask_i, .clk_en_req_i, .term_req_i, .cmd_ready_o, .cmd_ack_o,
    .rd_data_o, .rd_valid_o, .mem_addr_o, .mem_bank_o, .mem_clk_true_o, .mem_clk_comp_o,
    .mem_clk_en_o, .mem_rank_sel_n_o, .mem_row_strobe_n_o, .mem_col_strobe_n_o,
    .mem_write_en_n_o, .mem_term_ctrl_o, .mem_mask_low_o, .mem_mask_high_o, .mem_dq_i, .mem_dq_o,
    .mem_dq_oe_n_o, .mem_strobe_low_p_i, .mem_strobe_low_n_i, .mem_strobe_high_p_i,
    .mem_strobe_high_n_i, .mem_strobe_low_p_o, .mem_strobe_low_n_o, .mem_strobe_high_p_o,
    .mem_strobe_high_n_o, .mem_strobe_oe_n_o);
  ddrpin_mem_model u_mem (.mem_rank_sel_n_o, .mem_row_strobe_n_o, .mem_col_strobe_n_o,
    .mem_write_en_n_o, .mem_mask_low_o, .mem_mask_high_o, .mem_dq_o, .mem_dq_oe_n_o,
    .mem_strobe_low_p_o, .mem_strobe_high_p_o, .mem_strobe_oe_n_o, .rdat, .mem_dq_i,
    .mem_strobe_low_p_i, .mem_strobe_low_n_i, .mem_strobe_high_p_i, .mem_strobe_high_n_i, .wdat);
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task final_report;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // A hang counts as a mismatch and closes the run.
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      final_report;
    end
  end
  // Holds the request until acknowledged, then checks the command pins in that cycle.
  task cmd(input logic [2:0] c, input logic r, input logic [31:0] wd, input logic [3:0] wm);
    int i;
    @(posedge core_clk_i);
    cmd_code_i <= ddrpin_cmd_e'(c);
    {cmd_rank_i, cmd_bank_i, cmd_addr_i} <= {r, c, c, 13'h1ABC};
    {cmd_wdata_i, cmd_wmask_i, cmd_valid_i} <= {wd, wm, 1'b1};
    for (i = 0; i < 200 && cmd_ack_o !== 1'b1; i++) begin
      @(posedge core_clk_i);
      #1;
    end
    chk("pins", {29'h0, c}, {mem_row_strobe_n_o, mem_col_strobe_n_o, mem_write_en_n_o});
    chk("rank", r ? 32'h1 : 32'h2, mem_rank_sel_n_o);
    chk("bank", {29'h0, c}, mem_bank_o);
    chk("addr", {16'h0, c, 13'h1ABC}, mem_addr_o);
    @(posedge core_clk_i);
    cmd_valid_i <= 1'b0;
    for (i = 0; i < 300 && cmd_ready_o !== 1'b1; i++) begin
      @(posedge core_clk_i);
      #1;
    end
  endtask : cmd
  task t_reset;
    @(posedge core_clk_i);
    #1;
    chk("cke", 32'h0, mem_clk_en_o);
    chk("masks", 32'h3, {mem_mask_high_o, mem_mask_low_o});
    chk("drives", 32'h7, {mem_strobe_oe_n_o, mem_dq_oe_n_o});
    $display("reset test done");
  endtask : t_reset
  // Memory clock rate and polarity, then enable and termination follow requests.
  task t_clock(input logic ce, input logic [1:0] tm);
    int n, e;
    logic p;
    {n, e, p} = {32'h0, 32'h0, 1'b1};
    @(posedge core_clk_i);
    {clk_en_req_i, term_req_i} <= {ce, tm};
    #1;
    p = mem_clk_true_o;  // Start from the real level so no rise is missed.
    repeat (80) begin
      @(posedge core_clk_i);
      #1;
      if (mem_clk_comp_o !== ~mem_clk_true_o) e++;
      if (mem_clk_true_o === 1'b1 && p === 1'b0) n++;
      p = mem_clk_true_o;
    end
    chk("clk opposite", 0, e);
    chk("clk rises", 10, n);
    chk("cke", {31'h0, ce}, mem_clk_en_o);
    chk("term", {30'h0, tm}, mem_term_ctrl_o);
    $display("clock test done");
  endtask : t_clock
  task t_cmds;
    for (int c = 0; c < 8; c++) if (c != 5) cmd(c[2:0], c[0], 32'h0, 4'h0);
    $display("command test done");
  endtask : t_cmds
  task t_write;
    cmd(3'h4, 1'b0, 32'hA1B2C3D4, 4'h6);
    chk("written", 32'hA10000D4, wdat);
    $display("write test done");
  endtask : t_write
  task t_read;
    int n;
    logic [15:0] b [2];
    n = 0;
    // Beats return while the command still waits for ready, so watch alongside it.
    fork
      cmd(3'h5, 1'b1, 32'h0, 4'h0);
      repeat (60) begin
        @(posedge core_clk_i);
        #1;
        if (rd_valid_o === 1'b1) begin
          if (n < 2) b[n] = rd_data_o;
          n++;
        end
      end
    join
    chk("beats", 2, n);
    chk("beat0", 32'h96E1, b[0]);
    chk("beat1", 32'h5A3C, b[1]);
    $display("read test done");
  endtask : t_read
  initial begin
    {sys_rst_i, cmd_valid_i, cmd_rank_i, clk_en_req_i, term_req_i} = 6'h20;
    {cmd_bank_i, cmd_addr_i, cmd_wdata_i, cmd_wmask_i} = 55'h0;
    cmd_code_i = CMD_NOP;
    repeat (16) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    t_reset;
    t_clock(1'b1, 2'h2);
    t_clock(1'b1, 2'h1);
    t_cmds;
    t_write;
    t_read;
    final_report;
  end
endmodule : tb_top
